// File: bench/test_dcsr_regs.sv
/*
  Self-checking bench for the deinterlacer register bank: reset values,
  read/write masks, shadow transfer, sticky flags, interrupt and soft reset.
  Assumes the bank's own assertions watch the datapath relations.
*/
module test_dcsr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] VER_EXP = 32'h0100_0000;
  logic i_mclk, i_rstn, i_wr, i_rd, stable, pd;
  logic [9:0] i_addr, tl, th;
  logic [31:0] i_wdata, rdata, ba, bb, bc, m, v;
  logic [6:0] ev;
  logic [10:0] mh, mw, fh, fw;
  logic [15:0] sc;
  logic byp, acc, act, mot, dia, rgb, ntsc, seg, p32, p22, swp, tm, td;
  logic crst, irq;
  logic [1:0] pk;
  logic [31:0] vals [8];
  int num_errors, n_compared, n;

  dcsr_regs #(.SOFT_RST_CYCLES(2)) i_dcsr_regs (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_frame_end(ev[0]),
    .i_in_frame_start(ev[1]), .i_raster_stable(stable),
    .i_meas_height(mh), .i_meas_width(mw), .i_fifo_overrun(ev[2]),
    .i_pd_locked(pd), .i_fs_wr_mark(ev[3]), .i_fs_wr_err(ev[4]),
    .i_fs_rd_err(ev[6:5]), .o_bypass(byp), .o_accept_video(acc),
    .o_active_only(act), .o_motion_on(mot), .o_diag_on(dia), .o_rgb(rgb),
    .o_packing(pk), .o_ntsc_order(ntsc), .o_segmented_frame_mode(seg),
    .o_pd32_en(p32), .o_pd22_en(p22), .o_phase_swap(swp),
    .o_tint_motion(tm), .o_tint_diag(td), .o_frame_height(fh),
    .o_frame_width(fw), .o_low_motion_threshold(tl),
    .o_high_motion_threshold(th), .o_blend_scale(sc), .o_buf_a_base(ba),
    .o_buf_b_base(bb), .o_buf_c_base(bc), .o_core_reset(crst), .o_irq(irq)
  );

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic end_sim();
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(negedge i_mclk);
  endtask

  task automatic rchk(input string nm, input logic [9:0] a,
                      input logic [31:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    chk(nm, e, rdata);
  endtask

  task automatic pulse(input logic [6:0] msk);
    @(posedge i_mclk);
    ev <= msk;
    @(posedge i_mclk);
    ev <= 7'h00;
    @(negedge i_mclk);
  endtask

  // field masks of the plain data registers, height first
  function automatic logic [31:0] fmask(input int i);
    case (i)
      0, 1: fmask = 32'h0000_07ff;
      2, 3: fmask = 32'h0000_03ff;
      4: fmask = 32'h0000_ffff;
      default: fmask = 32'hffff_ffff;
    endcase
  endfunction

  initial begin
    // generous: the sequence needs well under two thousand cycles
    #1_000_000;
    num_errors++;
    end_sim();
  end

  initial begin
    i_rstn = 1'b0;
    {i_wr, i_rd, stable, pd} = 4'h0;
    i_addr = 10'h000;
    i_wdata = 32'h0000_0000;
    ev = 7'h00;
    mh = 11'h000;
    mw = 11'h000;
    v = $urandom(19);
    repeat (3) @(posedge i_mclk);
    i_rstn <= 1'b1;
    for (int i = 0; i < 13; i++) rchk("reset", 10'(4 * i), 32'h0000_0000);
    rchk("soft_rst", dcsr_pkg::ADDR_SOFT_RST, 32'h0000_0000);
    wr(dcsr_pkg::ADDR_VERSION, 32'hffff_ffff);
    rchk("version", dcsr_pkg::ADDR_VERSION, VER_EXP);
    chk("bypass", 32'h1, {31'h0, byp});
    for (int i = 0; i < 8; i++) begin
      vals[i] = $urandom & fmask(i);
      wr(10'(dcsr_pkg::ADDR_HEIGHT + 4 * i), vals[i] | ~fmask(i));
      rchk("data_reg", 10'(dcsr_pkg::ADDR_HEIGHT + 4 * i), vals[i]);
    end
    chk("height_held", 32'h0, {21'h0, fh});
    // first transfer with an unstable raster: no sync event yet
    wr(dcsr_pkg::ADDR_CONTROL, 32'h0000_0001);
    pulse(7'h01);
    chk("height", vals[0], {21'h0, fh});
    chk("width", vals[1], {21'h0, fw});
    chk("low_thr", vals[2], {22'h0, tl});
    chk("high_thr", vals[3], {22'h0, th});
    chk("scale", vals[4], {16'h0, sc});
    chk("bufs", vals[5] ^ vals[6] ^ vals[7], ba ^ bb ^ bc);
    rchk("flags", dcsr_pkg::ADDR_FLAGS, 32'h0000_0041);
    wr(dcsr_pkg::ADDR_FLAGS, 32'h0000_0fff);
    @(posedge i_mclk);
    stable <= 1'b1;
    mh <= vals[0][10:0];
    mw <= vals[1][10:0];
    wr(dcsr_pkg::ADDR_IRQ_EN, 32'h0000_0041);
    for (int k = 0; k < 4; k++) begin
      m = $urandom;
      m[1:0] = 2'(k);
      m[4:3] = 2'(k % 3);
      m[6] = m[6] & m[1];
      wr(dcsr_pkg::ADDR_MODE, m);
      m = m & dcsr_pkg::MODE_MASK;
      rchk("mode", dcsr_pkg::ADDR_MODE, m);
      wr(dcsr_pkg::ADDR_CONTROL, 32'h0000_0003);
      pulse(7'h01);
      chk("mode_out", {m[17:16], m[9:0]},
          {td, tm, swp, p22, p32, seg, ntsc, pk, rgb, mot, dia});
      chk("bypass", 32'h0, {31'h0, byp});
      chk("active", 32'h1, {31'h0, act});
      rchk("control", dcsr_pkg::ADDR_CONTROL, 32'h0000_0002);
      rchk("flags", dcsr_pkg::ADDR_FLAGS, (k == 0) ? 32'h43 : 32'h41);
      chk("irq", 32'h1, {31'h0, irq});
      wr(dcsr_pkg::ADDR_FLAGS, 32'h0000_0fff);
      rchk("flags_clr", dcsr_pkg::ADDR_FLAGS, 32'h0000_0000);
      chk("irq_clr", 32'h0, {31'h0, irq});
    end
    // armed then cancelled; raster now unstable
    wr(dcsr_pkg::ADDR_MODE, ~m & 32'hffff_ffbf);
    wr(dcsr_pkg::ADDR_CONTROL, 32'h0000_0003);
    wr(dcsr_pkg::ADDR_CONTROL, 32'h0000_0002);
    @(posedge i_mclk);
    stable <= 1'b0;
    pulse(7'h01);
    chk("cancel", {m[17:16], m[9:0]},
        {td, tm, swp, p22, p32, seg, ntsc, pk, rgb, mot, dia});
    rchk("flags", dcsr_pkg::ADDR_FLAGS, 32'h0000_0044);
    wr(dcsr_pkg::ADDR_FLAGS, 32'h0000_0fff);
    wr(dcsr_pkg::ADDR_IRQ_EN, 32'hffff_ffff);
    rchk("irq_en", dcsr_pkg::ADDR_IRQ_EN, 32'h0000_0f7f);
    @(posedge i_mclk);
    pd <= 1'b1;
    pulse(7'h7c);
    @(posedge i_mclk);
    pd <= 1'b0;
    pulse(7'h00);
    rchk("flags", dcsr_pkg::ADDR_FLAGS, 32'h0000_0f38);
    wr(dcsr_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(dcsr_pkg::ADDR_IRQ_EN, 32'h0000_0100);
    chk("irq_one", 32'h1, {31'h0, irq});
    wr(dcsr_pkg::ADDR_FLAGS, 32'h0000_0100);
    chk("irq_w1c", 32'h0, {31'h0, irq});
    wr(dcsr_pkg::ADDR_CONTROL, 32'h0000_0004);
    chk("accept_wait", 32'h0, {31'h0, acc});
    pulse(7'h02);
    chk("accept", 32'h1, {31'h0, acc});
    // clear of the update flag in its own set cycle: the event wins
    wr(dcsr_pkg::ADDR_CONTROL, 32'h0000_0005);
    fork
      wr(dcsr_pkg::ADDR_FLAGS, 32'h0000_0001);
      pulse(7'h01);
    join
    rchk("set_wins", dcsr_pkg::ADDR_FLAGS, 32'h0000_0e79);
    wr(dcsr_pkg::ADDR_SOFT_RST, 32'h0000_0001);
    n = 0;
    repeat (8) begin
      if (crst === 1'b1) n++;
      @(negedge i_mclk);
    end
    chk("purge_len", 32'd2, 32'(n));
    rchk("soft_rst", dcsr_pkg::ADDR_SOFT_RST, 32'h0000_0000);
    rchk("control", dcsr_pkg::ADDR_CONTROL, 32'h0000_0000);
    rchk("mode", dcsr_pkg::ADDR_MODE, 32'h0000_0000);
    rchk("irq_en", dcsr_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    rchk("flags_kept", dcsr_pkg::ADDR_FLAGS, 32'h0000_0e79);
    rchk("height_kept", dcsr_pkg::ADDR_HEIGHT, vals[0]);
    chk("purge_out", 32'h2, {30'h0, byp, acc});
    end_sim();
  end
endmodule // test_dcsr_regs

// File: hdl/dcsr_flags.sv
/*
  Sticky status flags with write-one-to-clear and a masked interrupt.
  Assumes event pulses and clear masks are synchronous to i_mclk.
*/
module dcsr_flags (
  input wire logic i_mclk,
  input wire logic i_rstn,
  dcsr_flag_if.unit fl
);
  genvar g;
  generate
    for (g = 0; g < dcsr_pkg::NUM_FLAGS; g++) begin : g_flag
      if (dcsr_pkg::FLAG_MASK[g]) begin : g_used
        // an event in the clearing cycle keeps the flag set
        always_ff @(posedge i_mclk or negedge i_rstn) begin
          if (!i_rstn) begin
            fl.flags[g] <= 1'b0;
          end else if (fl.event_set[g]) begin
            fl.flags[g] <= 1'b1;
          end else if (fl.clear[g]) begin
            fl.flags[g] <= 1'b0;
          end
        end
      end else begin : g_hole
        assign fl.flags[g] = 1'b0;
      end
    end
  endgenerate

  assign fl.irq = |(fl.flags & fl.enable);

  set_wins_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (fl.event_set[0] && fl.clear[0]) |=> fl.flags[0])
    else $error("flag lost when event met clear");
  irq_mask_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (fl.flags == '0) |-> !fl.irq)
    else $error("interrupt without any flag");
endmodule // dcsr_flags

// File: hdl/dcsr_regs.sv
/*
  Control and status register bank of a video deinterlacer core.
  Assumes a single-cycle register port, pulses from the video datapath
  synchronous to i_mclk, and a datapath that honours the shadowed outputs.
*/
module dcsr_regs #(
  parameter int SOFT_RST_CYCLES = dcsr_pkg::SOFT_RST_CYC,
  // version fields: arbitrary values
  parameter logic [3:0] VER_REV = 4'h0,
  parameter logic [3:0] VER_MINOR = 4'h0,
  parameter logic [7:0] VER_MAJOR = 8'h01
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [9:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_frame_end,
  input wire logic i_in_frame_start,
  input wire logic i_raster_stable,
  input wire logic [dcsr_pkg::SIZE_W-1:0] i_meas_height,
  input wire logic [dcsr_pkg::SIZE_W-1:0] i_meas_width,
  input wire logic i_fifo_overrun,
  input wire logic i_pd_locked,
  input wire logic i_fs_wr_mark,
  input wire logic i_fs_wr_err,
  input wire logic [1:0] i_fs_rd_err,
  output logic o_bypass,
  output logic o_accept_video,
  output logic o_active_only,
  output logic o_motion_on,
  output logic o_diag_on,
  output logic o_rgb,
  output logic [1:0] o_packing,
  output logic o_ntsc_order,
  output logic o_segmented_frame_mode,
  output logic o_pd32_en,
  output logic o_pd22_en,
  output logic o_phase_swap,
  output logic o_tint_motion,
  output logic o_tint_diag,
  output logic [dcsr_pkg::SIZE_W-1:0] o_frame_height,
  output logic [dcsr_pkg::SIZE_W-1:0] o_frame_width,
  output logic [dcsr_pkg::THR_W-1:0] o_low_motion_threshold,
  output logic [dcsr_pkg::THR_W-1:0] o_high_motion_threshold,
  output logic [dcsr_pkg::SCALE_W-1:0] o_blend_scale,
  output logic [31:0] o_buf_a_base,
  output logic [31:0] o_buf_b_base,
  output logic [31:0] o_buf_c_base,
  output logic o_core_reset,
  output logic o_irq
);
  localparam int NF = dcsr_pkg::NUM_FLAGS;
  localparam int SW = dcsr_pkg::SIZE_W;
  localparam int TW = dcsr_pkg::THR_W;
  if (SOFT_RST_CYCLES < 1 || SOFT_RST_CYCLES > 65535) begin : g_chk
    $error("SOFT_RST_CYCLES out of range");
  end
  // software-visible registers
  logic [dcsr_pkg::CTL_W-1:0] core_control;
  logic [31:0] operating_mode;
  logic [NF-1:0] interrupt_enable;
  logic [SW-1:0] frame_height;
  logic [SW-1:0] frame_width;
  logic [TW-1:0] low_motion_threshold;
  logic [TW-1:0] high_motion_threshold;
  logic [dcsr_pkg::SCALE_W-1:0] blend_scale;
  logic [31:0] field_buffer_a_base;
  logic [31:0] field_buffer_b_base;
  logic [31:0] field_buffer_c_base;
  logic software_reset;

  logic [31:0] shadow_mode;
  logic shadow_enable;
  logic in_sync;
  logic pd_locked_d;
  logic [15:0] rst_count;
  dcsr_pkg::dcsr_rst_e rst_state;
  logic wr_ctl;
  logic do_update;
  logic soft_clear;
  logic [31:0] next_rdata;
  logic sync_now;
  dcsr_flag_if fl ();
  dcsr_flags u_flags (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .fl(fl)
  );
  assign wr_ctl = i_wr && (i_addr == dcsr_pkg::ADDR_CONTROL);
  // a write in the boundary cycle can cancel an armed update but not arm one; a purge swallows the boundary
  assign do_update = i_frame_end && core_control[dcsr_pkg::CTL_UPDATE]
                     && !(wr_ctl && !i_wdata[dcsr_pkg::CTL_UPDATE])
                     && !soft_clear;
  assign soft_clear = (rst_state == dcsr_pkg::DCSR_PURGE);
  // control register: update bit drops after the transfer
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      core_control <= '0;
    end else if (soft_clear) begin
      core_control <= '0;
    end else if (wr_ctl) begin
      core_control <= i_wdata[dcsr_pkg::CTL_W-1:0];
    end else if (do_update) begin
      core_control[dcsr_pkg::CTL_UPDATE] <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      operating_mode <= dcsr_pkg::RESET_WORD;
      interrupt_enable <= '0;
    end else if (soft_clear) begin
      operating_mode <= dcsr_pkg::RESET_WORD;
      interrupt_enable <= '0;
    end else if (i_wr) begin
      if (i_addr == dcsr_pkg::ADDR_MODE) begin
        operating_mode <= i_wdata & dcsr_pkg::MODE_MASK;
      end
      if (i_addr == dcsr_pkg::ADDR_IRQ_EN) begin
        interrupt_enable <= i_wdata[NF-1:0] & dcsr_pkg::FLAG_MASK;
      end
    end
  end

  // sizes, thresholds and bases survive a soft reset
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      frame_height <= '0;
      frame_width <= '0;
      low_motion_threshold <= '0;
      high_motion_threshold <= '0;
      blend_scale <= '0;
      field_buffer_a_base <= dcsr_pkg::RESET_WORD;
      field_buffer_b_base <= dcsr_pkg::RESET_WORD;
      field_buffer_c_base <= dcsr_pkg::RESET_WORD;
    end else if (i_wr) begin
      case (i_addr)
        dcsr_pkg::ADDR_HEIGHT: frame_height <= i_wdata[SW-1:0];
        dcsr_pkg::ADDR_WIDTH: frame_width <= i_wdata[SW-1:0];
        dcsr_pkg::ADDR_LOW_THR: low_motion_threshold <= i_wdata[TW-1:0];
        dcsr_pkg::ADDR_HIGH_THR: high_motion_threshold <= i_wdata[TW-1:0];
        dcsr_pkg::ADDR_SCALE: blend_scale <= i_wdata[dcsr_pkg::SCALE_W-1:0];
        dcsr_pkg::ADDR_BUF_A: field_buffer_a_base <= i_wdata;
        dcsr_pkg::ADDR_BUF_B: field_buffer_b_base <= i_wdata;
        dcsr_pkg::ADDR_BUF_C: field_buffer_c_base <= i_wdata;
        default: ;
      endcase
    end
  end

  // shadow copies: the datapath never sees a half-written setting
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      shadow_mode <= dcsr_pkg::RESET_WORD;
      shadow_enable <= 1'b0;
      o_frame_height <= '0;
      o_frame_width <= '0;
      o_low_motion_threshold <= '0;
      o_high_motion_threshold <= '0;
      o_blend_scale <= '0;
      o_buf_a_base <= dcsr_pkg::RESET_WORD;
      o_buf_b_base <= dcsr_pkg::RESET_WORD;
      o_buf_c_base <= dcsr_pkg::RESET_WORD;
    end else if (soft_clear) begin
      shadow_mode <= dcsr_pkg::RESET_WORD;
      shadow_enable <= 1'b0;
    end else if (do_update) begin
      shadow_mode <= operating_mode;
      shadow_enable <= core_control[dcsr_pkg::CTL_ENABLE];
      o_frame_height <= frame_height;
      o_frame_width <= frame_width;
      o_low_motion_threshold <= low_motion_threshold;
      o_high_motion_threshold <= high_motion_threshold;
      o_blend_scale <= blend_scale;
      o_buf_a_base <= field_buffer_a_base;
      o_buf_b_base <= field_buffer_b_base;
      o_buf_c_base <= field_buffer_c_base;
    end
  end

  // accept-video follows its own input-frame boundary, not the shadow
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_accept_video <= 1'b0;
    end else if (soft_clear) begin
      o_accept_video <= 1'b0;
    end else if (i_in_frame_start) begin
      o_accept_video <= core_control[dcsr_pkg::CTL_ACCEPT];
    end
  end

  assign o_bypass = !shadow_enable;
  assign o_active_only = 1'b1;
  assign o_motion_on = shadow_mode[dcsr_pkg::MODE_ALG_LSB+1];
  assign o_diag_on = shadow_mode[dcsr_pkg::MODE_ALG_LSB];
  assign o_rgb = shadow_mode[dcsr_pkg::MODE_RGB];
  assign o_packing = shadow_mode[dcsr_pkg::MODE_PACK_LSB +: 2];
  assign o_ntsc_order = shadow_mode[dcsr_pkg::MODE_ORDER];
  // motion is not forced on: software owns that pairing
  assign o_segmented_frame_mode = shadow_mode[dcsr_pkg::MODE_SEGFRM];
  assign o_pd32_en = shadow_mode[dcsr_pkg::MODE_PD32];
  assign o_pd22_en = shadow_mode[dcsr_pkg::MODE_PD22];
  assign o_phase_swap = shadow_mode[dcsr_pkg::MODE_SWAP];
  assign o_tint_motion = shadow_mode[dcsr_pkg::MODE_TINT_MOT];
  assign o_tint_diag = shadow_mode[dcsr_pkg::MODE_TINT_DIAG];

  // raster check, judged once per frame against the shadowed sizes
  assign sync_now = i_raster_stable && (i_meas_height == o_frame_height)
                    && (i_meas_width == o_frame_width);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      in_sync <= 1'b0;
      pd_locked_d <= 1'b0;
    end else begin
      pd_locked_d <= i_pd_locked;
      if (i_frame_end) begin
        in_sync <= sync_now;
      end
    end
  end

  always_comb begin
    fl.event_set = '0;
    fl.event_set[dcsr_pkg::FLG_UPDATE] = do_update;
    fl.event_set[dcsr_pkg::FLG_SYNC_ON] = i_frame_end && sync_now
                                          && !in_sync;
    fl.event_set[dcsr_pkg::FLG_SYNC_OFF] = i_frame_end && !sync_now
                                           && in_sync;
    fl.event_set[dcsr_pkg::FLG_OVERRUN] = i_fifo_overrun;
    fl.event_set[dcsr_pkg::FLG_PD_ON] = i_pd_locked && !pd_locked_d;
    fl.event_set[dcsr_pkg::FLG_PD_OFF] = !i_pd_locked && pd_locked_d;
    fl.event_set[dcsr_pkg::FLG_FRAME] = i_frame_end;
    fl.event_set[dcsr_pkg::FLG_WR_MARK] = i_fs_wr_mark;
    fl.event_set[dcsr_pkg::FLG_WR_ERR] = i_fs_wr_err;
    fl.event_set[dcsr_pkg::FLG_RD_ERR0 +: 2] = i_fs_rd_err;
  end

  assign fl.clear = (i_wr && i_addr == dcsr_pkg::ADDR_FLAGS)
                    ? i_wdata[NF-1:0] : '0;
  assign fl.enable = interrupt_enable;
  assign o_irq = fl.irq;
  // soft reset: bit holds for the purge time, then drops by itself
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_state <= dcsr_pkg::DCSR_RUN;
      rst_count <= '0;
      software_reset <= 1'b0;
    end else begin
      case (rst_state)
        dcsr_pkg::DCSR_RUN: begin
          if (i_wr && i_addr == dcsr_pkg::ADDR_SOFT_RST
              && i_wdata[dcsr_pkg::SOFT_RST_BIT]) begin
            rst_state <= dcsr_pkg::DCSR_PURGE;
            rst_count <= 16'(SOFT_RST_CYCLES - 1);
            software_reset <= 1'b1;
          end
        end
        dcsr_pkg::DCSR_PURGE: begin
          if (rst_count == '0) begin
            rst_state <= dcsr_pkg::DCSR_RUN;
            software_reset <= 1'b0;
          end else begin
            rst_count <= rst_count - 16'h0001;
          end
        end
        default: begin
          rst_state <= dcsr_pkg::DCSR_RUN;
          software_reset <= 1'b0;
        end
      endcase
    end
  end
  assign o_core_reset = software_reset;
  always_comb begin
    next_rdata = dcsr_pkg::RESET_WORD;
    case (i_addr)
      dcsr_pkg::ADDR_CONTROL: next_rdata[dcsr_pkg::CTL_W-1:0] = core_control;
      dcsr_pkg::ADDR_MODE: next_rdata = operating_mode;
      dcsr_pkg::ADDR_IRQ_EN: next_rdata[NF-1:0] = interrupt_enable;
      dcsr_pkg::ADDR_FLAGS: next_rdata[NF-1:0] = fl.flags;
      dcsr_pkg::ADDR_HEIGHT: next_rdata[SW-1:0] = frame_height;
      dcsr_pkg::ADDR_WIDTH: next_rdata[SW-1:0] = frame_width;
      dcsr_pkg::ADDR_LOW_THR: next_rdata[TW-1:0] = low_motion_threshold;
      dcsr_pkg::ADDR_HIGH_THR: next_rdata[TW-1:0] = high_motion_threshold;
      dcsr_pkg::ADDR_SCALE: next_rdata[dcsr_pkg::SCALE_W-1:0] = blend_scale;
      dcsr_pkg::ADDR_BUF_A: next_rdata = field_buffer_a_base;
      dcsr_pkg::ADDR_BUF_B: next_rdata = field_buffer_b_base;
      dcsr_pkg::ADDR_BUF_C: next_rdata = field_buffer_c_base;
      dcsr_pkg::ADDR_VERSION: begin
        next_rdata[dcsr_pkg::VER_REV_LSB +: 4] = VER_REV;
        next_rdata[dcsr_pkg::VER_MIN_LSB +: 4] = VER_MINOR;
        next_rdata[dcsr_pkg::VER_MAJ_LSB +: 8] = VER_MAJOR;
      end
      dcsr_pkg::ADDR_SOFT_RST:
        next_rdata[dcsr_pkg::SOFT_RST_BIT] = software_reset;
      default: next_rdata = dcsr_pkg::RESET_WORD;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= dcsr_pkg::RESET_WORD;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= dcsr_pkg::RESET_WORD;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  shadow_arm_a: assert property (do_update |=>
    shadow_mode == $past(operating_mode) && !core_control[0])
    else $error("shadow transfer did not copy mode");
  cancel_a: assert property ((wr_ctl && !i_wdata[0]) |-> !do_update)
    else $error("cancelled update still taken");
  bypass_a: assert property (do_update |=> o_bypass ==
    !$past(core_control[dcsr_pkg::CTL_ENABLE]))
    else $error("bypass level wrong");
  accept_hold_a: assert property (!i_in_frame_start && !soft_clear
    |=> $stable(o_accept_video)) else $error("accept changed mid frame");
  update_flag_a: assert property (do_update |=> fl.flags[0])
    else $error("update flag not set");
  frame_flag_a: assert property (i_frame_end |=> fl.flags[6])
    else $error("frame flag not set");
  irq_cause_a: assert property (o_irq ==
    |(fl.flags & interrupt_enable)) else $error("irq not masked flags");
  version_ro_a: assert property (i_rd && i_addr ==
    dcsr_pkg::ADDR_VERSION |=> o_rdata[31:24] == VER_MAJOR
    && o_rdata[15:0] == 16'h0000) else $error("version read wrong");
  soft_len_a: assert property ($rose(software_reset) |->
    software_reset[*2]) else $error("soft reset too short");
  soft_zero_a: assert property (soft_clear |=> operating_mode == '0
    && interrupt_enable == '0) else $error("soft reset left settings");
  update_c: cover property (do_update);
  sync_c: cover property (fl.event_set[dcsr_pkg::FLG_SYNC_ON]);
  soft_c: cover property ($fell(software_reset));
  irq_c: cover property ($rose(o_irq));
endmodule // dcsr_regs

// File: inc/dcsr_flag_if.sv
/*
  Carrier between the register bank and its sticky flag unit.
  Assumes both ends sit on the same clock.
*/
interface dcsr_flag_if;
  logic [dcsr_pkg::NUM_FLAGS-1:0] event_set;
  logic [dcsr_pkg::NUM_FLAGS-1:0] clear;
  logic [dcsr_pkg::NUM_FLAGS-1:0] enable;
  logic [dcsr_pkg::NUM_FLAGS-1:0] flags;
  logic irq;
  modport bank (output event_set, output clear, output enable,
                input flags, input irq);
  modport unit (input event_set, input clear, input enable,
                output flags, output irq);
endinterface

// File: inc/dcsr_pkg.sv
/*
  Constants for the deinterlacer control and status register bank:
  register offsets, field positions, flag indices, reset values, timing.
  Assumes a 10 MHz register/video clock and 32-bit register words.
*/
package dcsr_pkg;
  // byte offsets on the register port
  localparam logic [9:0] ADDR_CONTROL = 10'h000;
  localparam logic [9:0] ADDR_MODE = 10'h004;
  localparam logic [9:0] ADDR_IRQ_EN = 10'h008;
  localparam logic [9:0] ADDR_FLAGS = 10'h00c;
  localparam logic [9:0] ADDR_HEIGHT = 10'h010;
  localparam logic [9:0] ADDR_WIDTH = 10'h014;
  localparam logic [9:0] ADDR_LOW_THR = 10'h018;
  localparam logic [9:0] ADDR_HIGH_THR = 10'h01c;
  localparam logic [9:0] ADDR_SCALE = 10'h020;
  localparam logic [9:0] ADDR_BUF_A = 10'h024;
  localparam logic [9:0] ADDR_BUF_B = 10'h028;
  localparam logic [9:0] ADDR_BUF_C = 10'h02c;
  localparam logic [9:0] ADDR_VERSION = 10'h0f0;
  localparam logic [9:0] ADDR_SOFT_RST = 10'h100;

  // control bits
  localparam int CTL_UPDATE = 0;
  localparam int CTL_ENABLE = 1;
  localparam int CTL_ACCEPT = 2;
  localparam int CTL_W = 3;

  // mode fields
  localparam int MODE_ALG_LSB = 0;
  localparam int MODE_RGB = 2;
  localparam int MODE_PACK_LSB = 3;
  localparam int MODE_ORDER = 5;
  localparam int MODE_SEGFRM = 6;
  localparam int MODE_PD32 = 7;
  localparam int MODE_PD22 = 8;
  localparam int MODE_SWAP = 9;
  localparam int MODE_TINT_MOT = 16;
  localparam int MODE_TINT_DIAG = 17;
  localparam logic [31:0] MODE_MASK = 32'h0003_03ff;

  // flag indices, shared by enable and status registers
  localparam int NUM_FLAGS = 12;
  localparam int FLG_UPDATE = 0;
  localparam int FLG_SYNC_ON = 1;
  localparam int FLG_SYNC_OFF = 2;
  localparam int FLG_OVERRUN = 3;
  localparam int FLG_PD_ON = 4;
  localparam int FLG_PD_OFF = 5;
  localparam int FLG_FRAME = 6;
  localparam int FLG_WR_MARK = 8;
  localparam int FLG_WR_ERR = 9;
  localparam int FLG_RD_ERR0 = 10;
  localparam logic [11:0] FLAG_MASK = 12'h0f7f;

  // field widths, version and soft reset bit positions, reset word
  localparam int SIZE_W = 11;
  localparam int THR_W = 10;
  localparam int SCALE_W = 16;
  localparam int VER_REV_LSB = 16;
  localparam int VER_MIN_LSB = 20;
  localparam int VER_MAJ_LSB = 24;
  localparam int SOFT_RST_BIT = 0;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // soft reset purge time
  localparam int CLK_PERIOD_NS = 100;
  localparam int SOFT_RST_NS = 1000;
  localparam int SOFT_RST_CYC = (SOFT_RST_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    DCSR_RUN = 2'b01,
    DCSR_PURGE = 2'b10
  } dcsr_rst_e;

  typedef enum logic [1:0] {
    DCSR_ALG_FIELD = 2'h0,
    DCSR_ALG_DIAG = 2'h1,
    DCSR_ALG_MOTION = 2'h2,
    DCSR_ALG_BOTH = 2'h3
  } dcsr_alg_e;
endpackage
